// ==== src/fbc_pkg.sv ====
// Package for the feeder bay control and interlock block.
// Assumes one synchronous clock domain; all ports synchronous to clk_in.
package fbc_pkg;
   localparam int N_OBJ = 3;
   localparam int N_EXT = 6;
   localparam int N_INT = 4;
   localparam int N_CFG = 10;
   localparam int N_SIG = 4;
   localparam int N_LED = 16;
   localparam int LED_SEL_W = 4;
   localparam int N_SCHEME = 4;
   localparam int PULSE_W = 16;
   localparam int ACC_W = 48;
   localparam int CNT_W = 32;
   localparam int PWR_W = 16;
   localparam int RATIO_W = 16;
   localparam int CUR_W = 16;
   localparam int DISP_W = 32;
   localparam int PULSE_BIT = 3;
   localparam logic [PULSE_W-1:0] PULSE_LEN_DEF = 16'h000a;
   localparam logic [1:0] ST_OPEN = 2'h1;
   localparam logic [1:0] ST_CLOSED = 2'h2;
   localparam int TRIP_LO = 8;
   localparam int TRIP_HI = 9;

   typedef struct packed {
      logic open_req;
      logic close_req;
   } fbc_cmd_t;

   typedef struct packed {
      logic [PULSE_W-1:0] pulse_len;
      logic [N_CFG-1:0] act_high;
      logic [1:0] scheme;
      logic user_prog;
      logic direct_en;
      logic energy_pulse;
   } fbc_cfg_t;

   typedef enum logic [1:0] {
      FBC_IDLE,
      FBC_PULSE_OPEN,
      FBC_PULSE_CLOSE
   } fbc_state_t;
endpackage : fbc_pkg

// ==== src/fbc_bay_ctrl.sv ====
// Feeder bay control: status, indication, interlock, command pulses, metering.
// Assumes synchronous inputs, interlock masks loaded by software as levels.
`timescale 1ns/1ps
// Function
// - Indicate position of at most three switching objects.
// - Control one object from local buttons or remote commands.
// - Each object status is a two-bit open/closed input pair.
// - Four-by-four lamp matrix, three lamps used, mapping configurable.
// - Open and close outputs drive only one of the objects.
// - Read six external inputs and four protection start/trip signals.
// - Each configurable input selectable active high or active low.
// - Red lamp lit while each external input is active.
// - Input assigned to open or close gives one pulse on activation.
// - Signalling outputs follow their assigned inputs as levels.
// - Commands are checked against the interlock, then executed or cancelled.
// - Interlock conditions use object statuses and active input states.
// - Protection trips open the breaker ungated by the interlock.
// - Built-in default interlock schemes chosen with the object configuration.
// - Normally outputs pulse on operator open or close commands and assigned inputs.
// - Direct control program drives outputs from statuses, inputs, selector.
// - Energy from accumulated power or pulse count on external input bit 3.
// - Two milliampere readings scaled to megawatt and megavar values.
// - Current transformer ratio converts phase currents to primary values.
// - Protection trip routed to the open output besides commanded opening.
module fbc_bay_ctrl (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [2*fbc_pkg::N_OBJ-1:0] status_pairs_in,
   input wire logic [fbc_pkg::N_EXT-1:0] ext_inputs_in,
   input wire logic [fbc_pkg::N_INT-1:0] prot_inputs_in,
   input wire fbc_pkg::fbc_cfg_t cfg_in,
   input wire fbc_pkg::fbc_cmd_t local_cmd_in,
   input wire fbc_pkg::fbc_cmd_t remote_cmd_in,
   input wire logic remote_sel_in,
   input wire logic [1:0] ctrl_obj_in,
   input wire logic [fbc_pkg::N_OBJ*fbc_pkg::LED_SEL_W-1:0] led_map_in,
   input wire logic [fbc_pkg::N_CFG-1:0] open_assign_in,
   input wire logic [fbc_pkg::N_CFG-1:0] close_assign_in,
   input wire logic [fbc_pkg::N_SIG*fbc_pkg::N_CFG-1:0] sig_assign_in,
   input wire logic [2*fbc_pkg::N_OBJ+fbc_pkg::N_CFG-1:0] ilk_open_mask_in,
   input wire logic [2*fbc_pkg::N_OBJ+fbc_pkg::N_CFG-1:0] ilk_open_val_in,
   input wire logic [2*fbc_pkg::N_OBJ+fbc_pkg::N_CFG-1:0] ilk_close_mask_in,
   input wire logic [2*fbc_pkg::N_OBJ+fbc_pkg::N_CFG-1:0] ilk_close_val_in,
   input wire logic [2*fbc_pkg::N_OBJ+fbc_pkg::N_CFG-1:0] dir_open_mask_in,
   input wire logic [2*fbc_pkg::N_OBJ+fbc_pkg::N_CFG-1:0] dir_open_val_in,
   input wire logic [2*fbc_pkg::N_OBJ+fbc_pkg::N_CFG-1:0] dir_close_mask_in,
   input wire logic [2*fbc_pkg::N_OBJ+fbc_pkg::N_CFG-1:0] dir_close_val_in,
   input wire logic [fbc_pkg::PWR_W-1:0] p_ma_in,
   input wire logic [fbc_pkg::PWR_W-1:0] q_ma_in,
   input wire logic [fbc_pkg::PWR_W-1:0] p_scale_in,
   input wire logic [fbc_pkg::PWR_W-1:0] q_scale_in,
   input wire logic power_valid_in,
   input wire logic [3*fbc_pkg::CUR_W-1:0] phase_cur_in,
   input wire logic [fbc_pkg::RATIO_W-1:0] ct_ratio_in,
   output logic [fbc_pkg::N_LED-1:0] led_matrix_out,
   output logic [fbc_pkg::N_OBJ-1:0] obj_fault_out,
   output logic [fbc_pkg::N_EXT-1:0] red_led_out,
   output logic open_out,
   output logic close_out,
   output logic [fbc_pkg::N_SIG-1:0] signal_out,
   output logic cmd_cancel_out,
   output logic [fbc_pkg::ACC_W-1:0] energy_out,
   output logic [fbc_pkg::DISP_W-1:0] mw_out,
   output logic [fbc_pkg::DISP_W-1:0] mvar_out,
   output logic [3*fbc_pkg::DISP_W-1:0] primary_cur_out
);
   localparam int CW = 2 * fbc_pkg::N_OBJ + fbc_pkg::N_CFG;

   function automatic logic cond_met(input logic [CW-1:0] cv, input logic [CW-1:0] m, input logic [CW-1:0] v);
      cond_met = ((cv ^ v) & m) == '0;
   endfunction : cond_met

   function automatic logic [1:0] obj_st(input logic [2*fbc_pkg::N_OBJ-1:0] p, input logic [1:0] i);
      obj_st = p[2*i +: 2];
   endfunction : obj_st

   logic [fbc_pkg::N_CFG-1:0] act_d;
   logic [fbc_pkg::N_CFG-1:0] act_q;
   logic [fbc_pkg::N_OBJ-1:0] valid_d;
   logic [CW-1:0] cond_d;
   logic ilk_open_ok;
   logic ilk_close_ok;
   logic cmd_open;
   logic cmd_close;
   logic dir_open_d;
   logic dir_close_d;
   logic dir_open_q;
   logic dir_close_q;
   logic in_open_edge;
   logic in_close_edge;
   logic trip_now;
   logic [1:0] ctrl_st;
   fbc_pkg::fbc_state_t state_q;
   logic [fbc_pkg::PULSE_W-1:0] pulse_cnt_q;
   logic [fbc_pkg::ACC_W-1:0] energy_q;
   logic pulse_in_q;
   logic [fbc_pkg::DISP_W-1:0] p_prod;
   logic [fbc_pkg::DISP_W-1:0] q_prod;
   logic [CW-1:0] dir_cv;

   // Active states of configurable inputs
   assign act_d = {prot_inputs_in, ext_inputs_in} ~^ cfg_in.act_high;

   // Pair is valid only when exactly one contact reports
   genvar g;
   generate
      for (g = 0; g < fbc_pkg::N_OBJ; g++) begin : g_valid
         assign valid_d[g] = status_pairs_in[2*g] ^ status_pairs_in[2*g+1];
      end
   endgenerate

   // Condition vector: statuses masked by validity, then inputs
   always_comb
   begin
      for (int i = 0; i < fbc_pkg::N_OBJ; i++)
      begin
         cond_d[2*i +: 2] = valid_d[i] ? status_pairs_in[2*i +: 2] : 2'h0;
      end
      cond_d[CW-1:2*fbc_pkg::N_OBJ] = act_d;
   end

   assign ctrl_st = obj_st(status_pairs_in, ctrl_obj_in);

   // Interlock: user program or built-in scheme
   always_comb
   begin
      ilk_open_ok = 1'b0;
      ilk_close_ok = 1'b0;
      if (cfg_in.user_prog)
      begin
         ilk_open_ok = cond_met(cond_d, ilk_open_mask_in, ilk_open_val_in);
         ilk_close_ok = cond_met(cond_d, ilk_close_mask_in, ilk_close_val_in);
      end
      else
      begin
         unique case (cfg_in.scheme)
            2'h0:
            begin
               ilk_open_ok = 1'b1;
               ilk_close_ok = 1'b1;
            end
            2'h1:
            begin
               ilk_open_ok = ctrl_st == fbc_pkg::ST_CLOSED;
               ilk_close_ok = ctrl_st == fbc_pkg::ST_OPEN;
            end
            2'h2:
            begin
               ilk_open_ok = ctrl_st == fbc_pkg::ST_CLOSED;
               ilk_close_ok = ctrl_st == fbc_pkg::ST_OPEN && obj_st(status_pairs_in, 2'h1) != fbc_pkg::ST_OPEN
                  && valid_d[1];
            end
            2'h3:
            begin
               ilk_open_ok = ctrl_st == fbc_pkg::ST_CLOSED;
               ilk_close_ok = ctrl_st == fbc_pkg::ST_OPEN && valid_d[1] && valid_d[2]
                  && obj_st(status_pairs_in, 2'h1) == obj_st(status_pairs_in, 2'h2);
            end
         endcase
      end
   end

   // Operator command by selected place
   assign cmd_open = remote_sel_in ? remote_cmd_in.open_req : local_cmd_in.open_req;
   assign cmd_close = remote_sel_in ? remote_cmd_in.close_req : local_cmd_in.close_req;

   // Direct control program; condition bit 0 is the selector
   assign dir_cv = {cond_d[CW-1:1], remote_sel_in};
   assign dir_open_d = cfg_in.direct_en && cond_met(dir_cv, dir_open_mask_in, dir_open_val_in);
   assign dir_close_d = cfg_in.direct_en && cond_met(dir_cv, dir_close_mask_in, dir_close_val_in);

   assign in_open_edge = |(act_d & ~act_q & open_assign_in) | (dir_open_d & ~dir_open_q);
   assign in_close_edge = |(act_d & ~act_q & close_assign_in) | (dir_close_d & ~dir_close_q);
   assign trip_now = act_d[fbc_pkg::TRIP_LO] | act_d[fbc_pkg::TRIP_HI];

   // Input history for edges
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         act_q <= '0;
         dir_open_q <= 1'b0;
         dir_close_q <= 1'b0;
      end
      else
      begin
         act_q <= act_d;
         dir_open_q <= dir_open_d;
         dir_close_q <= dir_close_d;
      end
   end

   // Pulse generator for open and close
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_q <= fbc_pkg::FBC_IDLE;
         pulse_cnt_q <= '0;
         cmd_cancel_out <= 1'b0;
      end
      else
      begin
         cmd_cancel_out <= 1'b0;
         unique case (state_q)
            fbc_pkg::FBC_IDLE:
            begin
               if ((cmd_open && ilk_open_ok) || in_open_edge)
               begin
                  state_q <= fbc_pkg::FBC_PULSE_OPEN;
                  pulse_cnt_q <= cfg_in.pulse_len;
               end
               else if ((cmd_close && ilk_close_ok) || in_close_edge)
               begin
                  state_q <= fbc_pkg::FBC_PULSE_CLOSE;
                  pulse_cnt_q <= cfg_in.pulse_len;
               end
               else if (cmd_open || cmd_close)
               begin
                  cmd_cancel_out <= 1'b1;
               end
            end
            fbc_pkg::FBC_PULSE_OPEN, fbc_pkg::FBC_PULSE_CLOSE:
            begin
               if (pulse_cnt_q <= 16'h0001)
               begin
                  state_q <= fbc_pkg::FBC_IDLE;
               end
               pulse_cnt_q <= pulse_cnt_q - 16'h0001;
            end
         endcase
      end
   end

   // Command outputs; trip bypasses interlock
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         open_out <= 1'b0;
         close_out <= 1'b0;
      end
      else
      begin
         open_out <= trip_now || state_q == fbc_pkg::FBC_PULSE_OPEN;
         close_out <= !trip_now && state_q == fbc_pkg::FBC_PULSE_CLOSE;
      end
   end

   // Indication and signalling levels
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         led_matrix_out <= '0;
         obj_fault_out <= '0;
         red_led_out <= '0;
         signal_out <= '0;
      end
      else
      begin
         for (int i = 0; i < fbc_pkg::N_LED; i++)
         begin
            led_matrix_out[i] <= 1'b0;
            for (int j = 0; j < fbc_pkg::N_OBJ; j++)
            begin
               if (led_map_in[j*fbc_pkg::LED_SEL_W +: fbc_pkg::LED_SEL_W] == i[3:0]
                  && obj_st(status_pairs_in, j[1:0]) == fbc_pkg::ST_CLOSED)
               begin
                  led_matrix_out[i] <= 1'b1;
               end
            end
         end
         obj_fault_out <= ~valid_d;
         red_led_out <= act_d[fbc_pkg::N_EXT-1:0];
         for (int s = 0; s < fbc_pkg::N_SIG; s++)
         begin
            signal_out[s] <= |(act_d & sig_assign_in[s*fbc_pkg::N_CFG +: fbc_pkg::N_CFG])
               | (cfg_in.direct_en & (dir_close_d | dir_open_d) & sig_assign_in[s*fbc_pkg::N_CFG]);
         end
      end
   end

   // Full-width power products
   assign p_prod = {16'h0000, p_ma_in} * {16'h0000, p_scale_in};
   assign q_prod = {16'h0000, q_ma_in} * {16'h0000, q_scale_in};

   // Energy from power or meter pulses
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         energy_q <= '0;
         pulse_in_q <= 1'b0;
      end
      else
      begin
         pulse_in_q <= ext_inputs_in[fbc_pkg::PULSE_BIT];
         if (cfg_in.energy_pulse)
         begin
            if (ext_inputs_in[fbc_pkg::PULSE_BIT] && !pulse_in_q)
            begin
               energy_q <= energy_q + 48'h1;
            end
         end
         else if (power_valid_in)
         begin
            energy_q <= energy_q + {{(fbc_pkg::ACC_W-fbc_pkg::DISP_W){1'b0}}, p_prod};
         end
      end
   end
   assign energy_out = energy_q;

   // Scaled power and primary currents
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         mw_out <= '0;
         mvar_out <= '0;
         primary_cur_out <= '0;
      end
      else
      begin
         mw_out <= p_prod;
         mvar_out <= q_prod;
         for (int k = 0; k < 3; k++)
         begin
            primary_cur_out[k*fbc_pkg::DISP_W +: fbc_pkg::DISP_W] <=
               phase_cur_in[k*fbc_pkg::CUR_W +: fbc_pkg::CUR_W] * ct_ratio_in;
         end
      end
   end

   a_trip_opens: assert property (@(posedge clk_in) disable iff (rst_in)
      trip_now |=> open_out && !close_out) else $error("trip did not open");
   a_ilk_blocks: assert property (@(posedge clk_in) disable iff (rst_in)
      state_q == fbc_pkg::FBC_IDLE && cmd_close && !ilk_close_ok && !in_close_edge && !in_open_edge
      && !(cmd_open && ilk_open_ok) |=> state_q == fbc_pkg::FBC_IDLE) else $error("blocked close ran");
   a_cancel_flag: assert property (@(posedge clk_in) disable iff (rst_in)
      state_q == fbc_pkg::FBC_IDLE && cmd_open && !ilk_open_ok && !cmd_close && !in_open_edge
      && !in_close_edge |=> cmd_cancel_out) else $error("no cancel");
   a_pulse_start: assert property (@(posedge clk_in) disable iff (rst_in)
      state_q == fbc_pkg::FBC_IDLE && cmd_open && ilk_open_ok |=> ##1 open_out) else $error("no open");
   a_pulse_len: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(state_q == fbc_pkg::FBC_PULSE_CLOSE) && pulse_cnt_q == 16'h0005
      |-> (state_q == fbc_pkg::FBC_PULSE_CLOSE) [*5] ##1 state_q == fbc_pkg::FBC_IDLE) else $error("len");
   a_red_led: assert property (@(posedge clk_in) disable iff (rst_in)
      ##1 red_led_out == $past(act_d[fbc_pkg::N_EXT-1:0])) else $error("red lamp wrong");
   a_fault_pair: assert property (@(posedge clk_in) disable iff (rst_in)
      status_pairs_in[0] == status_pairs_in[1] |=> obj_fault_out[0]) else $error("fault missed");
   a_sig_level: assert property (@(posedge clk_in) disable iff (rst_in)
      |(act_d & sig_assign_in[0 +: fbc_pkg::N_CFG]) |=> signal_out[0]) else $error("sig");
   a_act_level: assert property (@(posedge clk_in) disable iff (rst_in)
      !cfg_in.act_high[0] && !ext_inputs_in[0] |=> red_led_out[0]) else $error("polarity");

   c_open_cmd: cover property (@(posedge clk_in) disable iff (rst_in) cmd_open && ilk_open_ok ##2 open_out);
   c_cancel: cover property (@(posedge clk_in) disable iff (rst_in) cmd_cancel_out);
   c_trip: cover property (@(posedge clk_in) disable iff (rst_in) trip_now ##1 open_out);
   c_direct: cover property (@(posedge clk_in) disable iff (rst_in) dir_close_d && !dir_close_q);
endmodule : fbc_bay_ctrl

// ==== verif/fbc_gear_model.sv ====
// Switchgear model: auxiliary contacts of three objects and the controlled breaker.
// Assumes open/close coil levels from the block; other objects set by the bench.
`timescale 1ns/1ps
module fbc_gear_model #(
   parameter int TRAVEL = 3
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic open_in,
   input wire logic close_in,
   input wire logic [1:0] ctrl_obj_in,
   input wire logic [5:0] other_pairs_in,
   output logic [5:0] status_pairs_out
);
   logic closed_q;
   logic tgt_q;
   logic [3:0] travel_q;
   // Breaker moves TRAVEL+2 edges after the coil asserts, contacts both open in travel
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         closed_q <= 1'b1;
         tgt_q <= 1'b1;
         travel_q <= 4'h0;
      end
      else
      begin
         if (open_in)
            tgt_q <= 1'b0;
         else if (close_in)
            tgt_q <= 1'b1;
         if (tgt_q != closed_q)
         begin
            if (travel_q == 4'(TRAVEL))
            begin
               closed_q <= tgt_q;
               travel_q <= 4'h0;
            end
            else
               travel_q <= travel_q + 4'h1;
         end
      end
   end
   always_comb
   begin
      status_pairs_out = other_pairs_in;
      if (tgt_q != closed_q)
         status_pairs_out[2*ctrl_obj_in +: 2] = 2'h0;
      else
         status_pairs_out[2*ctrl_obj_in +: 2] = closed_q ? fbc_pkg::ST_CLOSED : fbc_pkg::ST_OPEN;
   end
endmodule : fbc_gear_model

// ==== verif/fbc_bay_ctrl_tb_top.sv ====
// Testbench of the feeder bay control block with a switchgear model.
// Assumes the hand-over latencies: command pulse two edges after request.
`timescale 1ns/1ps
module fbc_bay_ctrl_tb_top;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [5:0] pairs, other = 6'h0, ext = 6'h0;
   logic [3:0] prot = 4'h0, sig;
   fbc_pkg::fbc_cfg_t cfg = '{16'h0005, 10'h3ff, 2'h0, 1'b0, 1'b0, 1'b0};
   fbc_pkg::fbc_cmd_t lcmd = '0, rcmd = '0;
   logic rsel = 1'b0, pvld = 1'b0, op, cl, canc;
   logic [1:0] cobj = 2'h0;
   logic [11:0] lmap = 12'h765;
   logic [9:0] oas = 10'h0, cas = 10'h0;
   logic [39:0] sas = 40'h0;
   logic [15:0] iom = 16'h0, iov = 16'h0, pma = 16'h0002, qma = 16'h0004, psc = 16'h0003, qsc = 16'h0005;
   logic [15:0] ratio = 16'h000a, led;
   logic [15:0] icm = 16'h0, icv = 16'h0, dom = 16'h0, dov = 16'h0, dcm = 16'h0, dcv = 16'h0;
   logic [47:0] pcur = 48'h0003_0002_0001, en, en0;
   logic [2:0] flt;
   logic [5:0] red;
   logic [31:0] mw, mvar;
   logic [95:0] pri;
   int fails = 0, compares = 0, n_op = 0, n_cl = 0, n_ca = 0, cycles = 0;

   fbc_gear_model i_fbc_gear_model (.clk_in(clk_in), .rst_in(rst_in), .open_in(op), .close_in(cl),
      .ctrl_obj_in(cobj), .other_pairs_in(other), .status_pairs_out(pairs));
   fbc_bay_ctrl i_fbc_bay_ctrl (.clk_in(clk_in), .rst_in(rst_in), .status_pairs_in(pairs),
      .ext_inputs_in(ext), .prot_inputs_in(prot), .cfg_in(cfg), .local_cmd_in(lcmd), .remote_cmd_in(rcmd),
      .remote_sel_in(rsel), .ctrl_obj_in(cobj), .led_map_in(lmap), .open_assign_in(oas),
      .close_assign_in(cas), .sig_assign_in(sas), .ilk_open_mask_in(iom), .ilk_open_val_in(iov),
      .ilk_close_mask_in(icm), .ilk_close_val_in(icv), .dir_open_mask_in(dom),
      .dir_open_val_in(dov), .dir_close_mask_in(dcm), .dir_close_val_in(dcv),
      .p_ma_in(pma), .q_ma_in(qma), .p_scale_in(psc), .q_scale_in(qsc), .power_valid_in(pvld),
      .phase_cur_in(pcur), .ct_ratio_in(ratio), .led_matrix_out(led), .obj_fault_out(flt),
      .red_led_out(red), .open_out(op), .close_out(cl), .signal_out(sig), .cmd_cancel_out(canc),
      .energy_out(en), .mw_out(mw), .mvar_out(mvar), .primary_cur_out(pri));

   always #5 clk_in = ~clk_in;
   // Output pulse counters and run limit
   always @(posedge clk_in)
   begin
      n_op += int'(op === 1'b1);
      n_cl += int'(cl === 1'b1);
      n_ca += int'(canc === 1'b1);
      cycles++;
      if (cycles == 3000)
      begin
         fails++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict

   task automatic chk(input string nm, input logic [95:0] e, input logic [95:0] g);
      compares++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : step

   // One-cycle request, then counts over a window
   task automatic cmd(input logic rem, input logic o, input logic c, input int po, input int pc, input int pca);
      n_op = 0;
      n_cl = 0;
      n_ca = 0;
      if (rem)
         rcmd = '{o, c};
      else
         lcmd = '{o, c};
      step(1);
      lcmd = '0;
      rcmd = '0;
      step(14);
      chk("open pulse", 96'(po), 96'(n_op));
      chk("close pulse", 96'(pc), 96'(n_cl));
      chk("cancel", 96'(pca), 96'(n_ca));
   endtask : cmd

   task automatic t_indicate();
      other = 6'b11_01_00;
      step(4);
      chk("lamps", 96'h0020, 96'(led));
      chk("fault", 96'h4, 96'(flt));
      chk("idle", 96'h0, 96'({op, cl, canc}));
   endtask : t_indicate

   task automatic t_local();
      lcmd = '{1'b1, 1'b0};
      step(2);
      lcmd = '{1'b0, 1'b1};
      chk("open start", 96'h1, 96'(op));
      step(1);
      lcmd = '0;
      step(12);
      chk("open length", 96'h5, 96'(n_op));
      chk("close refused", 96'h0, 96'(n_cl + n_ca));
      cmd(1'b0, 1'b0, 1'b1, 0, 5, 0);
      cmd(1'b1, 1'b1, 1'b0, 0, 0, 0);
      rsel = 1'b1;
      cmd(1'b0, 1'b1, 1'b0, 0, 0, 0);
      cmd(1'b1, 1'b1, 1'b0, 5, 0, 0);
      rsel = 1'b0;
   endtask : t_local

   task automatic t_scheme();
      cfg.scheme = 2'h1;
      cmd(1'b0, 1'b1, 1'b0, 0, 0, 1);
      cfg.scheme = 2'h2;
      cmd(1'b0, 1'b0, 1'b1, 0, 0, 1);
      other = 6'b11_10_00;
      cfg.scheme = 2'h3;
      cmd(1'b0, 1'b0, 1'b1, 0, 0, 1);
      cfg.scheme = 2'h1;
      cmd(1'b0, 1'b0, 1'b1, 0, 5, 0);
      cfg.scheme = 2'h0;
      cfg.user_prog = 1'b1;
      iom = 16'h0040;
      iov = 16'h0040;
      cmd(1'b0, 1'b1, 1'b0, 0, 0, 1);
      ext = 6'h01;
      cmd(1'b0, 1'b1, 1'b0, 5, 0, 0);
      icm = 16'h0003;
      icv = 16'h0001;
      cmd(1'b0, 1'b0, 1'b1, 0, 5, 0);
      cmd(1'b0, 1'b0, 1'b1, 0, 0, 1);
      icm = 16'h0000;
      ext = 6'h00;
   endtask : t_scheme

   task automatic t_levels();
      cfg.act_high = 10'h3fe;
      sas = 40'h2;
      ext = 6'h02;
      step(4);
      chk("red lamps", 96'h03, 96'(red));
      chk("signal on", 96'h1, 96'(sig));
      ext = 6'h01;
      step(4);
      chk("red lamps", 96'h00, 96'(red));
      chk("signal off", 96'h0, 96'(sig));
      cfg.act_high = 10'h3ff;
      sas = 40'h0;
      cas = 10'h010;
      n_cl = 0;
      ext = 6'h10;
      step(20);
      chk("assigned close", 96'h5, 96'(n_cl));
      ext = 6'h00;
      cas = 10'h0;
   endtask : t_levels

   task automatic t_direct();
      cfg.direct_en = 1'b1;
      sas = 40'h1;
      dcm = 16'h0081;
      dcv = 16'h0081;
      dom = 16'h0081;
      dov = 16'h0080;
      n_op = 0;
      n_cl = 0;
      rsel = 1'b1;
      ext = 6'h02;
      step(3);
      chk("direct signal", 96'h1, 96'(sig));
      step(12);
      chk("direct close", 96'h5, 96'(n_cl));
      rsel = 1'b0;
      step(15);
      chk("direct open", 96'h5, 96'(n_op));
      ext = 6'h00;
      step(2);
      chk("direct signal off", 96'h0, 96'(sig));
      cfg.direct_en = 1'b0;
      sas = 40'h0;
   endtask : t_direct

   task automatic t_trip();
      iov = 16'h0000;
      sas = 40'h10000;
      prot = 4'h1;
      step(2);
      chk("start signal", 96'h2, 96'(sig));
      prot = 4'h4;
      step(2);
      chk("trip open", 96'h1, 96'(op));
      cmd(1'b0, 1'b0, 1'b1, 15, 0, 0);
      prot = 4'h0;
      step(3);
      chk("trip end", 96'h0, 96'(op));
      cfg.user_prog = 1'b0;
      sas = 40'h0;
   endtask : t_trip

   task automatic t_meter();
      chk("mw", 96'h6, 96'(mw));
      chk("mvar", 96'h14, 96'(mvar));
      chk("primary", {32'h1e, 32'h14, 32'h0a}, pri);
      cfg.energy_pulse = 1'b1;
      step(2);
      en0 = en;
      repeat (3)
      begin
         ext = 6'h08;
         step(2);
         ext = 6'h00;
         step(2);
      end
      chk("pulse energy", 96'(en0 + 48'h3), 96'(en));
      cfg.energy_pulse = 1'b0;
      step(2);
      en0 = en;
      pvld = 1'b1;
      step(2);
      pvld = 1'b0;
      step(3);
      chk("power energy", 96'(en0 + 48'hc), 96'(en));
   endtask : t_meter

   initial
   begin
      step(16);
      rst_in = 1'b0;
      step(1);
      t_indicate();
      t_local();
      t_scheme();
      t_levels();
      t_direct();
      t_trip();
      t_meter();
      give_verdict();
   end
endmodule : fbc_bay_ctrl_tb_top
